// >>> design/gwb_consts.svh
`ifndef GWB_CONSTS_SVH
`define GWB_CONSTS_SVH
// register byte offsets
`define GWB_OFS_CTRL 8'h00
`define GWB_OFS_GAIN_SEL 8'h04
`define GWB_OFS_GAIN_VAL 8'h08
`define GWB_OFS_AG_REQ 8'h0c
`define GWB_OFS_AG_WIN 8'h10
`define GWB_OFS_AG_TGT 8'h14
`define GWB_OFS_AG_RES 8'h18
`define GWB_OFS_WB_REQ 8'h1c
`define GWB_OFS_WB_PRESET 8'h20
`define GWB_OFS_WB_WIN 8'h24
`define GWB_OFS_WB_RES 8'h28
`define GWB_OFS_BLK_SEL 8'h2c
`define GWB_OFS_BLK_VAL 8'h30
// field positions
`define GWB_CTRL_BYPASS 0
`define GWB_CTRL_PERCH 1
`define GWB_CTRL_TEST_LSB 2
`define GWB_WIN_OFS_LSB 16
// channel selector codes
`define GWB_SEL_MASTER 2'h0
`define GWB_SEL_RED 2'h1
`define GWB_SEL_GREEN 2'h2
`define GWB_SEL_BLUE 2'h3
// white balance request codes
`define GWB_WB_OFF 2'h0
`define GWB_WB_WINDOW 2'h1
`define GWB_WB_BEST 2'h2
// auto gain result codes
`define GWB_AG_IDLE 3'h0
`define GWB_AG_PROC 3'h1
`define GWB_AG_OK 3'h2
`define GWB_AG_TIMEOUT 3'h3
`define GWB_AG_CANNOT 3'h4
// white balance result codes
`define GWB_WR_IDLE 4'h0
`define GWB_WR_PROC 4'h1
`define GWB_WR_OK 4'h2
`define GWB_WR_OK_BE 4'h3
`define GWB_WR_G_BRIGHT 4'h4
`define GWB_WR_G_DARK 4'h5
`define GWB_WR_TIMEOUT 4'h6
`define GWB_WR_TGT_HIGH 4'h7
`define GWB_WR_TGT_LOW 4'h8
// reset values and fixed gain
`define GWB_RST_GAIN 12'h100
`define GWB_RST_TGT 12'h800
`define GWB_RST_WIN_W 13'h1000
`define GWB_FIXED_GAIN 14'h0040
// preset red and blue trims, low, mid and high temperature
`define GWB_PRE_LO_R 12'h020
`define GWB_PRE_LO_B 12'h000
`define GWB_PRE_MID_R 12'h010
`define GWB_PRE_MID_B 12'h010
`define GWB_PRE_HI_R 12'h000
`define GWB_PRE_HI_B 12'h020
// convergence and limits
`define GWB_TOL 12'h010
`define GWB_TGT_MAX 12'he00
`define GWB_TGT_MIN 12'h100
// timing
`define GWB_TIMEOUT_S 10
`define GWB_CLK_HZ 50000000
`endif

// >>> design/gwb_ctrl.sv
// Overview of operation
// RQ1: bypass drops fixed gain, default off
// RQ2: colour has master and per-channel gain schemes
// RQ3: master scheme selects master, red, blue
// RQ4: per-channel scheme selects red, green, blue
// RQ5: software clears per-channel mode before auto gain
// RQ6: auto gain measures inside its window only
// RQ7: auto gain converges toward target level
// RQ8: auto gain request clears itself when done
// RQ9: auto gain reports idle, processing, succeeded
// RQ10: auto gain aborts with timeout after 10 s
// RQ11: refuse auto gain without image or test source
// RQ12: white balance only on colour variant
// RQ13: window mode measures window, aborts on failure
// RQ14: best-effort mode measures whole line
// RQ15: per-channel mode holds white balance off
// RQ16: white balance success reports and clears request
// RQ17: best-effort adjusts until timeout, reports condition
// RQ18: window mode times out after 10 s
// RQ19: window mode reports four distinct error codes
// RQ20: colour temperature presets, per-channel mode off
// RQ21: request off means no automatic adjustment
// RQ22: black selector master only or master/red/blue
// RQ23: results are distinct readable status codes
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "gwb_consts.svh"

module gwb_ctrl
  import gwb_pkg::*;
#(
  parameter bit COLOUR = 1'b1,
  parameter int unsigned TIMEOUT_CYC = `GWB_TIMEOUT_S * `GWB_CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire gwb_pix_t pix,
  input wire logic image_active,
  output gwb_gain_t gain_out,
  output gwb_black_t black_out
);

  gwb_state_t s;
  gwb_state_t n;
  logic [1:0] rcmp;
  logic [1:0] bcmp;
  logic [1:0] gcmp;
  logic in_win;
  logic [12:0] wo;
  logic [12:0] ww;
  logic [12:0] base_r;
  logic [12:0] base_b;
  logic g_bright;
  logic g_dark;
  logic tmo_hit;
  logic wr;
  logic [11:0] wv;

  // compare a against b with slack t: 0 within, 1 a low, 2 a high
  function automatic logic [1:0] cmp_s(input logic [25:0] a, input logic [25:0] b,
                                       input logic [25:0] t);
    logic [1:0] r;
    r = 2'h0;
    if (a + t < b) begin
      r = 2'h1;
    end else if (a > b + t) begin
      r = 2'h2;
    end
    return r;
  endfunction : cmp_s

  // selector legality per scheme and variant
  function automatic logic gsel_ok(input logic [1:0] sel, input logic per_ch);
    logic ok;
    ok = 1'b0;
    if (!COLOUR) begin
      ok = (sel == `GWB_SEL_MASTER);
    end else if (per_ch) begin
      ok = (sel != `GWB_SEL_MASTER); // see RQ4
    end else begin
      ok = (sel != `GWB_SEL_GREEN); // see RQ3
    end
    return ok;
  endfunction : gsel_ok

  // measurement window of the running job
  always_comb begin
    if (s.job == GJ_AG) begin
      wo = s.ag_o; // see RQ6
      ww = s.ag_w;
    end else if (s.wb_req == `GWB_WB_BEST) begin
      wo = 13'h0000; // see RQ14
      ww = 13'h1fff;
    end else begin
      wo = s.wb_o; // see RQ13
      ww = s.wb_w;
    end
    in_win = ({1'b0, pix.x} >= {1'b0, wo}) && ({1'b0, pix.x} < {1'b0, wo} + {1'b0, ww});
  end

  // line judgements against the target and against green
  always_comb begin
    gcmp = cmp_s({1'b0, s.sg}, 26'(s.ag_tgt * s.cnt), 26'(`GWB_TOL * s.cnt)); // see RQ7
    rcmp = cmp_s({1'b0, s.sr}, {1'b0, s.sg}, 26'(`GWB_TOL * s.cnt));
    bcmp = cmp_s({1'b0, s.sb}, {1'b0, s.sg}, 26'(`GWB_TOL * s.cnt));
    g_bright = ({2'b00, s.sg} > {s.sr, 2'b00}) || ({2'b00, s.sg} > {s.sb, 2'b00});
    g_dark = ({s.sg, 2'b00} < {2'b00, s.sr}) || ({s.sg, 2'b00} < {2'b00, s.sb});
    tmo_hit = (s.tmo >= TIMEOUT_CYC - 1);
    wr = psel && penable && s.pready && pwrite;
    wv = pwdata[11:0];
  end

  // next state: job engine, then bus writes, then gain mapping
  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // start a job on a pending request
    if (s.job == GJ_IDLE) begin
      if (s.ag_req) begin
        if (!image_active || s.test_src != 3'h0) begin
          n.ag_req = 1'b0; // see RQ11
          n.ag_res = `GWB_AG_CANNOT;
        end else begin
          n.job = GJ_AG;
          n.ag_res = `GWB_AG_PROC; // see RQ9
        end
      end else if (s.wb_req != `GWB_WB_OFF) begin // see RQ21
        if (s.wb_req == `GWB_WB_WINDOW && s.ag_tgt > `GWB_TGT_MAX) begin
          n.wb_req = `GWB_WB_OFF; // see RQ19
          n.wb_res = `GWB_WR_TGT_HIGH;
        end else if (s.wb_req == `GWB_WB_WINDOW && s.ag_tgt < `GWB_TGT_MIN) begin
          n.wb_req = `GWB_WB_OFF; // see RQ19
          n.wb_res = `GWB_WR_TGT_LOW;
        end else begin
          n.job = GJ_WB;
          n.wb_res = `GWB_WR_PROC;
        end
      end
      n.tmo = 32'h0;
      n.sr = 25'h0;
      n.sg = 25'h0;
      n.sb = 25'h0;
      n.cnt = 13'h0;
    end else begin
      n.tmo = tmo_hit ? s.tmo : s.tmo + 32'h1; // held at the limit, never passes it
      if (pix.valid && in_win) begin
        n.sr = s.sr + 25'(pix.r);
        n.sg = s.sg + 25'(pix.g);
        n.sb = s.sb + 25'(pix.b);
        n.cnt = s.cnt + 13'h1;
      end
      if (pix.line_end) begin
        n.sr = 25'h0;
        n.sg = 25'h0;
        n.sb = 25'h0;
        n.cnt = 13'h0;
      end
      if (s.job == GJ_AG) begin
        if (tmo_hit) begin
          n.job = GJ_IDLE; // see RQ10
          n.ag_req = 1'b0;
          n.ag_res = `GWB_AG_TIMEOUT;
        end else if (pix.line_end && s.cnt != 13'h0) begin
          if (gcmp == 2'h0) begin
            n.job = GJ_IDLE; // see RQ8
            n.ag_req = 1'b0;
            n.ag_res = `GWB_AG_OK;
          end else if (gcmp == 2'h1 && s.gm != 12'hfff) begin
            n.gm = s.gm + 12'h1;
          end else if (gcmp == 2'h2 && s.gm != 12'h000) begin
            n.gm = s.gm - 12'h1;
          end
        end
      end else begin
        if (tmo_hit) begin
          n.job = GJ_IDLE;
          n.wb_req = `GWB_WB_OFF;
          n.wb_res = (s.wb_req == `GWB_WB_BEST) ? `GWB_WR_OK_BE : `GWB_WR_TIMEOUT; // see RQ17, RQ18
        end else if (pix.line_end && s.cnt != 13'h0) begin
          if (s.wb_req == `GWB_WB_WINDOW && g_bright) begin
            n.job = GJ_IDLE; // see RQ13
            n.wb_req = `GWB_WB_OFF;
            n.wb_res = `GWB_WR_G_BRIGHT; // see RQ19
          end else if (s.wb_req == `GWB_WB_WINDOW && g_dark) begin
            n.job = GJ_IDLE;
            n.wb_req = `GWB_WB_OFF;
            n.wb_res = `GWB_WR_G_DARK; // see RQ19
          end else if (rcmp == 2'h0 && bcmp == 2'h0) begin
            n.job = GJ_IDLE; // see RQ16
            n.wb_req = `GWB_WB_OFF;
            n.wb_res = `GWB_WR_OK;
          end else begin
            // best effort keeps stepping even when a colour cannot match
            if (rcmp == 2'h1 && s.gr != 12'hfff) n.gr = s.gr + 12'h1; // see RQ17
            if (rcmp == 2'h2 && s.gr != 12'h000) n.gr = s.gr - 12'h1;
            if (bcmp == 2'h1 && s.gb != 12'hfff) n.gb = s.gb + 12'h1;
            if (bcmp == 2'h2 && s.gb != 12'h000) n.gb = s.gb - 12'h1;
          end
        end
      end
    end
    // access phase: one wait state, then answer
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (paddr)
        `GWB_OFS_CTRL: n.prdata = {27'h0, s.test_src, s.per_ch, s.bypass};
        `GWB_OFS_GAIN_SEL: n.prdata = {30'h0, s.gain_sel};
        `GWB_OFS_GAIN_VAL: begin
          case (s.gain_sel)
            `GWB_SEL_RED: n.prdata = {20'h0, s.gr};
            `GWB_SEL_GREEN: n.prdata = {20'h0, s.gg};
            `GWB_SEL_BLUE: n.prdata = {20'h0, s.gb};
            default: n.prdata = {20'h0, s.gm};
          endcase
        end
        `GWB_OFS_AG_REQ: n.prdata = {31'h0, s.ag_req};
        `GWB_OFS_AG_WIN: n.prdata = {3'h0, s.ag_o, 3'h0, s.ag_w};
        `GWB_OFS_AG_TGT: n.prdata = {20'h0, s.ag_tgt};
        `GWB_OFS_AG_RES: n.prdata = {29'h0, s.ag_res}; // see RQ23
        `GWB_OFS_WB_REQ: n.prdata = {30'h0, s.wb_req};
        `GWB_OFS_WB_PRESET: n.prdata = {30'h0, s.wb_preset};
        `GWB_OFS_WB_WIN: n.prdata = {3'h0, s.wb_o, 3'h0, s.wb_w};
        `GWB_OFS_WB_RES: n.prdata = {28'h0, s.wb_res}; // see RQ23
        `GWB_OFS_BLK_SEL: n.prdata = {30'h0, s.blk_sel};
        `GWB_OFS_BLK_VAL: begin
          case (s.blk_sel)
            `GWB_SEL_RED: n.prdata = {20'h0, s.blk.r};
            `GWB_SEL_BLUE: n.prdata = {20'h0, s.blk.b};
            default: n.prdata = {20'h0, s.blk.m};
          endcase
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // write takes effect on the edge that samples pready
    if (wr) begin
      case (paddr)
        `GWB_OFS_CTRL: begin
          n.bypass = pwdata[`GWB_CTRL_BYPASS];
          n.per_ch = COLOUR && pwdata[`GWB_CTRL_PERCH]; // see RQ2
          n.test_src = pwdata[`GWB_CTRL_TEST_LSB +: 3];
        end
        `GWB_OFS_GAIN_SEL: n.gain_sel = pwdata[1:0];
        `GWB_OFS_GAIN_VAL: begin
          if (gsel_ok(s.gain_sel, s.per_ch)) begin
            case (s.gain_sel)
              `GWB_SEL_RED: n.gr = wv; // see RQ3, RQ4
              `GWB_SEL_GREEN: n.gg = wv;
              `GWB_SEL_BLUE: n.gb = wv;
              default: n.gm = wv;
            endcase
          end
        end
        `GWB_OFS_AG_REQ: begin
          if (pwdata[0] && s.job == GJ_IDLE) n.ag_req = 1'b1;
        end
        `GWB_OFS_AG_WIN: begin
          n.ag_w = pwdata[12:0];
          n.ag_o = pwdata[`GWB_WIN_OFS_LSB +: 13];
        end
        `GWB_OFS_AG_TGT: n.ag_tgt = wv;
        `GWB_OFS_WB_REQ: begin
          if (COLOUR && s.job == GJ_IDLE && pwdata[1:0] != 2'h3) begin
            n.wb_req = pwdata[1:0]; // see RQ12
          end
        end
        `GWB_OFS_WB_PRESET: begin
          if (COLOUR && !s.per_ch) begin
            n.wb_preset = pwdata[1:0]; // see RQ20
            case (pwdata[1:0])
              2'h1: begin
                n.gr = `GWB_PRE_LO_R;
                n.gb = `GWB_PRE_LO_B;
              end
              2'h2: begin
                n.gr = `GWB_PRE_MID_R;
                n.gb = `GWB_PRE_MID_B;
              end
              2'h3: begin
                n.gr = `GWB_PRE_HI_R;
                n.gb = `GWB_PRE_HI_B;
              end
              default: ;
            endcase
          end
        end
        `GWB_OFS_WB_WIN: begin
          n.wb_w = pwdata[12:0];
          n.wb_o = pwdata[`GWB_WIN_OFS_LSB +: 13];
        end
        `GWB_OFS_BLK_SEL: n.blk_sel = pwdata[1:0];
        `GWB_OFS_BLK_VAL: begin
          if (s.blk_sel == `GWB_SEL_MASTER) begin
            n.blk.m = wv; // see RQ22
          end else if (COLOUR && s.blk_sel == `GWB_SEL_RED) begin
            n.blk.r = wv;
          end else if (COLOUR && s.blk_sel == `GWB_SEL_BLUE) begin
            n.blk.b = wv;
          end
        end
        default: ;
      endcase
    end
    // per-channel mode forces white balance off and stops its job
    if (n.per_ch) begin
      n.wb_req = `GWB_WB_OFF; // see RQ15
      if (s.job == GJ_WB) begin
        n.job = GJ_IDLE;
        n.wb_res = `GWB_WR_IDLE;
      end
    end
    // effective gains: master plus trims, or independent colours
    base_r = COLOUR ? (s.per_ch ? {1'b0, s.gr} : {1'b0, s.gm} + {1'b0, s.gr}) : {1'b0, s.gm};
    base_b = COLOUR ? (s.per_ch ? {1'b0, s.gb} : {1'b0, s.gm} + {1'b0, s.gb}) : {1'b0, s.gm};
    n.gain.r = {1'b0, base_r};
    n.gain.b = {1'b0, base_b};
    n.gain.g = (COLOUR && s.per_ch) ? {2'b00, s.gg} : {2'b00, s.gm};
    if (!s.bypass) begin
      n.gain.r = n.gain.r + `GWB_FIXED_GAIN; // see RQ1
      n.gain.g = n.gain.g + `GWB_FIXED_GAIN;
      n.gain.b = n.gain.b + `GWB_FIXED_GAIN;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.gm <= `GWB_RST_GAIN;
      s.gg <= `GWB_RST_GAIN;
      s.ag_tgt <= `GWB_RST_TGT;
      s.ag_w <= `GWB_RST_WIN_W;
      s.wb_w <= `GWB_RST_WIN_W;
      s.job <= GJ_IDLE;
    end else begin
      s <= n;
    end
  end

  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign gain_out = s.gain;
  assign black_out = s.blk;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_ag_refused: assert property (s.job == GJ_IDLE && s.ag_req && !image_active |=> // see RQ11
    s.ag_res == `GWB_AG_CANNOT && !s.ag_req && s.job == GJ_IDLE) else $error("ag not refused");
  a_ag_reports_proc: assert property (s.job == GJ_AG |-> s.ag_res == `GWB_AG_PROC) // see RQ9
    else $error("ag result not processing");
  a_ag_req_clears: assert property ($past(s.job) == GJ_AG && s.job == GJ_IDLE |-> // see RQ8
    !s.ag_req && s.ag_res inside {`GWB_AG_OK, `GWB_AG_TIMEOUT}) else $error("ag end wrong");
  a_tmo_bound: assert property (s.tmo < TIMEOUT_CYC) // see RQ10
    else $error("timeout counter overran");
  a_wb_forced_off: assert property (s.per_ch |=> s.wb_req == `GWB_WB_OFF) // see RQ15
    else $error("wb not forced off");
  a_wb_mono_none: assert property (!COLOUR |-> s.wb_req == `GWB_WB_OFF && s.job != GJ_WB) // see RQ12
    else $error("wb on mono");
  a_wb_end_codes: assert property ($past(s.job) == GJ_WB && s.job == GJ_IDLE |-> // see RQ16
    s.wb_req == `GWB_WB_OFF && s.wb_res != `GWB_WR_PROC) else $error("wb end wrong");
  a_bypass_gain: assert property (s.bypass && !s.per_ch && $stable(s.gm) && $stable(s.bypass) // see RQ1
    |=> s.gain.g == {2'b00, $past(s.gm)}) else $error("bypass gain wrong");
  a_gain_sel_write: assert property (wr && paddr == `GWB_OFS_GAIN_VAL && s.job == GJ_IDLE // see RQ3
    && !s.per_ch && s.gain_sel == `GWB_SEL_GREEN |=> $stable(s.gg)) else $error("green written");
  a_apb_wait: assert property (psel && penable && !s.pready |=> s.pready ##1 !s.pready)
    else $error("apb wait state wrong");

  c_ag_ok: cover property (s.job == GJ_AG ##1 s.ag_res == `GWB_AG_OK);
  c_wb_be: cover property (s.wb_res == `GWB_WR_OK_BE);
  c_wb_bright: cover property (s.wb_res == `GWB_WR_G_BRIGHT);

endmodule : gwb_ctrl

// >>> design/gwb_pkg.sv
package gwb_pkg;
  typedef enum logic [1:0] {GJ_IDLE, GJ_AG, GJ_WB} gwb_job_t;

  typedef struct packed {
    logic valid;
    logic line_end;
    logic [12:0] x;
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] b;
  } gwb_pix_t;

  typedef struct packed {
    logic [13:0] r;
    logic [13:0] g;
    logic [13:0] b;
  } gwb_gain_t;

  typedef struct packed {
    logic [11:0] m;
    logic [11:0] r;
    logic [11:0] b;
  } gwb_black_t;

  typedef struct packed {
    logic bypass;
    logic per_ch;
    logic [2:0] test_src;
    logic [1:0] gain_sel;
    logic [1:0] blk_sel;
    logic [11:0] gm;
    logic [11:0] gr;
    logic [11:0] gg;
    logic [11:0] gb;
    gwb_black_t blk;
    logic ag_req;
    logic [12:0] ag_w;
    logic [12:0] ag_o;
    logic [11:0] ag_tgt;
    logic [2:0] ag_res;
    logic [1:0] wb_req;
    logic [1:0] wb_preset;
    logic [12:0] wb_w;
    logic [12:0] wb_o;
    logic [3:0] wb_res;
    gwb_job_t job;
    logic [31:0] tmo;
    logic [24:0] sr;
    logic [24:0] sg;
    logic [24:0] sb;
    logic [12:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    gwb_gain_t gain;
  } gwb_state_t;
endpackage : gwb_pkg

// >>> dv/gain_white_balance_black_level_ctrl_tb.sv
`timescale 1ns/1ps
`include "gwb_consts.svh"
module gain_white_balance_black_level_ctrl_tb
  import gwb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  gwb_pix_t pix;
  logic image_active;
  gwb_gain_t gain_out;
  gwb_black_t black_out;
  logic run = 1'b0;
  logic [11:0] lvl_r = 12'h000;
  logic [11:0] lvl_g = 12'h000;
  logic [11:0] lvl_b = 12'h000;
  logic [31:0] rdata;
  logic err;
  int n_mismatch = 0;
  int cmp_count = 0;
  // auto gain cases: image, control, expected result, target, green level
  logic [35:0] agt [4] = '{36'h0_1_4_400_400, 36'h1_5_4_400_400,
                           36'h1_1_2_400_400, 36'h1_1_3_100_400};
  // white cases: mode, expected result, target, red, green, blue
  logic [55:0] wbt [7] = '{56'h1_2_400_400_400_400, 56'h1_7_f00_400_400_400,
                           56'h1_8_080_400_400_400, 56'h1_4_400_080_400_080,
                           56'h1_5_400_400_080_400, 56'h1_6_400_400_300_300,
                           56'h2_3_400_400_300_300};

  always #10 ref_clk = ~ref_clk;

  gwb_ctrl #(.COLOUR(1'b1), .TIMEOUT_CYC(200)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pix(pix), .image_active(image_active), .gain_out(gain_out), .black_out(black_out)
  );

  gwb_pix_src src (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(run), .lvl_r(lvl_r), .lvl_g(lvl_g),
    .lvl_b(lvl_b), .pix(pix), .image_active(image_active)
  );

  task complete_run;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      complete_run();
    end
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(exp, rdata);
  endtask : rd

  // read a result register until it leaves idle and processing
  task poll(input logic [7:0] a);
    int i;
    for (i = 0; i < 200; i++) begin
      xfer(1'b0, a, 32'h0);
      if (rdata !== 32'h0 && rdata !== 32'h1) break;
    end
    if (i == 200) begin
      n_mismatch++;
      complete_run();
    end
  endtask : poll

  task settle;
    repeat (3) @(negedge ref_clk);
  endtask : settle

  // main sequence
  initial begin
    int k;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle();
    chk(32'h140, 32'(gain_out.r));
    chk(32'h140, 32'(gain_out.g));
    chk(32'h0, 32'(black_out.m));
    rd(`GWB_OFS_AG_RES, 32'(`GWB_AG_IDLE));
    rd(`GWB_OFS_WB_RES, 32'(`GWB_WR_IDLE));
    wr(`GWB_OFS_CTRL, 32'h1);
    settle();
    chk(32'h100, 32'(gain_out.g));
    wr(`GWB_OFS_GAIN_SEL, 32'(`GWB_SEL_RED));
    wr(`GWB_OFS_GAIN_VAL, 32'h5);
    settle();
    chk(32'h105, 32'(gain_out.r));
    chk(32'h100, 32'(gain_out.b));
    wr(`GWB_OFS_CTRL, 32'h3);
    wr(`GWB_OFS_GAIN_SEL, 32'(`GWB_SEL_GREEN));
    wr(`GWB_OFS_GAIN_VAL, 32'h200);
    settle();
    chk(32'h200, 32'(gain_out.g));
    wr(`GWB_OFS_WB_REQ, 32'(`GWB_WB_WINDOW));
    rd(`GWB_OFS_WB_REQ, 32'(`GWB_WB_OFF));
    rd(`GWB_OFS_WB_RES, 32'(`GWB_WR_IDLE));
    wr(`GWB_OFS_CTRL, 32'h0);
    settle();
    chk(32'h140, 32'(gain_out.g));
    wr(`GWB_OFS_GAIN_VAL, 32'h300);
    rd(`GWB_OFS_GAIN_VAL, 32'h200);
    for (k = 1; k < 4; k++) begin
      wr(`GWB_OFS_WB_PRESET, 32'(k));
      settle();
      chk(32'h140 + 32'h10 * (3 - k), 32'(gain_out.r));
      chk(32'h140 + 32'h10 * (k - 1), 32'(gain_out.b));
    end
    for (k = 0; k < 3; k++) begin
      wr(`GWB_OFS_BLK_SEL, (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : 32'h3);
      wr(`GWB_OFS_BLK_VAL, 32'h10 + 32'(k));
    end
    settle();
    chk(32'h10, 32'(black_out.m));
    chk(32'h11, 32'(black_out.r));
    chk(32'h12, 32'(black_out.b));
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      run <= agt[k][32];
      lvl_g <= agt[k][11:0];
      wr(`GWB_OFS_CTRL, 32'(agt[k][31:28]));
      wr(`GWB_OFS_AG_WIN, 32'h0004_0008);
      wr(`GWB_OFS_AG_TGT, 32'(agt[k][23:12]));
      wr(`GWB_OFS_AG_REQ, 32'h1);
      poll(`GWB_OFS_AG_RES);
      chk(32'(agt[k][27:24]), rdata);
      if (agt[k][27:24] == 4'h2) begin
        rd(`GWB_OFS_AG_REQ, 32'h0);
      end
    end
    for (k = 0; k < 7; k++) begin
      run <= 1'b1;
      lvl_r <= wbt[k][35:24];
      lvl_g <= wbt[k][23:12];
      lvl_b <= wbt[k][11:0];
      wr(`GWB_OFS_CTRL, 32'h1);
      wr(`GWB_OFS_AG_TGT, 32'(wbt[k][47:36]));
      wr(`GWB_OFS_WB_WIN, 32'h0004_0008);
      wr(`GWB_OFS_WB_REQ, 32'(wbt[k][55:52]));
      poll(`GWB_OFS_WB_RES);
      chk(32'(wbt[k][51:48]), rdata);
      if (wbt[k][51:48] == 4'h2) begin
        rd(`GWB_OFS_WB_REQ, 32'h0);
      end
    end
    xfer(1'b0, 8'h40, 32'h0);
    chk(32'h1, 32'(err));
    chk(32'h0, rdata);
    complete_run();
  end
endmodule : gain_white_balance_black_level_ctrl_tb

// >>> dv/gwb_pix_src.sv
`timescale 1ns/1ps
module gwb_pix_src
  import gwb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [11:0] lvl_r,
  input wire logic [11:0] lvl_g,
  input wire logic [11:0] lvl_b,
  output gwb_pix_t pix,
  output logic image_active
);
  logic [12:0] x_q;
  logic tg_q;
  logic in_band;

  // column counter stands still while no image runs; toggle drives idle pattern
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      x_q <= 13'h0000;
      tg_q <= 1'b0;
    end else begin
      tg_q <= ~tg_q;
      if (run) begin
        x_q <= (x_q == 13'h000f) ? 13'h0000 : x_q + 13'h0001;
      end
    end
  end

  // 16-pixel lines; columns outside 4..11 saturate so a window slip shows
  assign in_band = (x_q >= 13'h0004) && (x_q < 13'h000c);
  always_comb begin
    pix.valid = run;
    pix.line_end = run && (x_q == 13'h000f);
    pix.x = x_q;
    pix.r = !run ? {12{tg_q}} : (in_band ? lvl_r : 12'hfff);
    pix.g = !run ? {12{tg_q}} : (in_band ? lvl_g : 12'hfff);
    pix.b = !run ? {12{tg_q}} : (in_band ? lvl_b : 12'hfff);
    image_active = run;
  end
endmodule : gwb_pix_src
